// File: hdl/qcs_classifier_scheduler.sv
// frame classifier into four queues and egress queue scheduler
// assumes config ports and descriptors come from same-clock logic
`timescale 1ns/1ps
module qcs_classifier_scheduler
   import qcs_pkg::*;
#(
   parameter int NPORT = 10,
   parameter int QDEPTH = 8
) (
   input logic clock_i,
   input logic srst_i,
   input qcs_policy_e policy_i,
   input qcs_ptype_e ptype_i,
   input logic [NPORT*2-1:0] port_level_i,
   input qcs_tab_wr_s cos_wr_i,
   input qcs_tab_wr_s dscp_wr_i,
   input logic in_valid_i,
   output logic in_ready_o,
   input qcs_desc_s in_data_i,
   output logic out_valid_o,
   input logic out_ready_i,
   output qcs_out_s out_data_o
);
   if (NPORT < 1 || NPORT > MAX_PORTS) begin : g_bad_nport
      $error("port count out of range");
   end
   // ****************************************
   // mapping tables
   // ****************************************
   logic [COS_N-1:0][1:0] cos_tab_ff, nxt_cos_tab;
   logic [DSCP_N-1:0][1:0] dscp_tab_ff, nxt_dscp_tab;
   always_comb begin
      nxt_cos_tab = cos_tab_ff;
      nxt_dscp_tab = dscp_tab_ff;
      if (cos_wr_i.we) begin
         nxt_cos_tab[cos_wr_i.addr[2:0]] = cos_wr_i.level;
      end
      if (dscp_wr_i.we) begin
         nxt_dscp_tab[dscp_wr_i.addr] = dscp_wr_i.level;
      end
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cos_tab_ff <= {COS_N{COS_RST}};
         dscp_tab_ff <= {DSCP_N{DSCP_RST}};
      end else begin
         cos_tab_ff <= nxt_cos_tab;
         dscp_tab_ff <= nxt_dscp_tab;
      end
   end
   // ****************************************
   // classifier
   // ****************************************
   logic [1:0] cls_q, port_q, cos_q, dscp_q;
   always_comb begin
      port_q = Q_LOWEST;
      if (int'(in_data_i.src_port) < NPORT) begin
         port_q = port_level_i[in_data_i.src_port*2 +: 2];
      end
      cos_q = in_data_i.cos_vld ? cos_tab_ff[in_data_i.cos] : Q_LOWEST;
      dscp_q = in_data_i.ip_vld ? dscp_tab_ff[in_data_i.dscp] : Q_LOWEST;
      unique case (ptype_i)
         PT_PORT: cls_q = port_q;
         PT_TOS_ONLY: cls_q = dscp_q;
         PT_COS_ONLY: cls_q = cos_q;
         PT_TOS_FIRST: cls_q = in_data_i.ip_vld ? dscp_q : cos_q;
         PT_COS_FIRST: cls_q = in_data_i.cos_vld ? cos_q : dscp_q;
         default: cls_q = Q_LOWEST;
      endcase
   end
   // ****************************************
   // ingress stage
   // ****************************************
   logic stg_vld_ff, nxt_stg_vld, in_rdy_ff, nxt_in_rdy;
   logic [1:0] stg_q_ff, nxt_stg_q;
   qcs_desc_s stg_desc_ff, nxt_stg_desc;
   logic [NQ-1:0] q_in_rdy, q_ne, q_pop;
   qcs_desc_s q_data [NQ];
   logic accept, push;
   assign accept = in_valid_i & in_rdy_ff;
   assign push = stg_vld_ff & q_in_rdy[stg_q_ff];
   always_comb begin
      nxt_stg_vld = accept | (stg_vld_ff & ~push);
      nxt_in_rdy = ~nxt_stg_vld;
      nxt_stg_q = accept ? cls_q : stg_q_ff;
      nxt_stg_desc = accept ? in_data_i : stg_desc_ff;
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         stg_vld_ff <= 1'b0;
         in_rdy_ff <= 1'b0;
         stg_q_ff <= Q_LOWEST;
         stg_desc_ff <= '0;
      end else begin
         stg_vld_ff <= nxt_stg_vld;
         in_rdy_ff <= nxt_in_rdy;
         stg_q_ff <= nxt_stg_q;
         stg_desc_ff <= nxt_stg_desc;
      end
   end
   assign in_ready_o = in_rdy_ff;
   // ****************************************
   // priority queues
   // ****************************************
   for (genvar k = 0; k < NQ; k++) begin : g_q
      qcs_fifo #(
         .W($bits(qcs_desc_s)),
         .DEPTH(QDEPTH)
      ) u_fifo (
         .clock_i(clock_i),
         .srst_i(srst_i),
         .in_valid_i(stg_vld_ff && stg_q_ff == 2'(k)),
         .in_ready_o(q_in_rdy[k]),
         .in_data_i(stg_desc_ff),
         .out_valid_o(q_ne[k]),
         .out_ready_i(q_pop[k]),
         .out_data_o(q_data[k])
      );
   end
   // ****************************************
   // scheduler
   // ****************************************
   logic [NQ-1:0][CRED_W-1:0] cred_ff, nxt_cred, cred_use;
   logic [NQ-1:0] elig;
   logic [1:0] sel;
   logic load, out_vld_ff, nxt_out_vld, reload;
   qcs_out_s out_ff, nxt_out;
   assign load = (~out_vld_ff | out_ready_i) & (q_ne != '0);
   always_comb begin
      cred_use = cred_ff;
      reload = 1'b0;
      for (int k = 0; k < NQ; k++) begin
         elig[k] = q_ne[k] & (cred_ff[k] != '0);
      end
      if (policy_i == POL_STRICT) begin
         elig = q_ne;
      end else if (elig == '0) begin
         cred_use = WEIGHTS;
         reload = 1'b1;
         elig = q_ne;
      end
      sel = Q_LOWEST;
      for (int k = NQ - 1; k >= 0; k--) begin
         if (elig[k]) begin
            sel = 2'(k);
         end
      end
      q_pop = '0;
      q_pop[sel] = load;
      nxt_cred = (policy_i == POL_STRICT) ? WEIGHTS : cred_use;
      if (load && policy_i == POL_WEIGHTED) begin
         nxt_cred[sel] = cred_use[sel] - 1'b1;
      end
      nxt_out_vld = load | (out_vld_ff & ~out_ready_i);
      nxt_out = out_ff;
      if (load) begin
         nxt_out.desc = q_data[sel];
         nxt_out.queue = sel;
      end
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cred_ff <= WEIGHTS;
         out_vld_ff <= 1'b0;
         out_ff <= '0;
      end else begin
         cred_ff <= nxt_cred;
         out_vld_ff <= nxt_out_vld;
         out_ff <= nxt_out;
      end
   end
   assign out_valid_o = out_vld_ff;
   assign out_data_o = out_ff;
   // ****************************************
   // assertions
   // ****************************************
   a_wrr_credit_use: assert property (@(posedge clock_i)
      disable iff (srst_i)
      load && policy_i == POL_WEIGHTED |-> cred_use[sel] != '0)
      else $error("weighted pick from queue without credit");
   a_wrr_high_reload: assert property (@(posedge clock_i)
      disable iff (srst_i)
      reload && load && policy_i == POL_WEIGHTED && sel == Q_HIGH
      |=> cred_ff[0] == 4'h7)
      else $error("high credit not seven after reload");
   a_strict_order: assert property (@(posedge clock_i)
      disable iff (srst_i)
      load && policy_i == POL_STRICT && sel != Q_HIGH
      |-> (q_ne & ((4'h1 << sel) - 4'h1)) == '0)
      else $error("strict served lower queue while higher waited");
   a_disable_lowest: assert property (@(posedge clock_i)
      disable iff (srst_i)
      accept && ptype_i == PT_DISABLE |=> stg_q_ff == Q_LOWEST)
      else $error("disabled source not lowest");
   a_port_level: assert property (@(posedge clock_i)
      disable iff (srst_i)
      accept && ptype_i == PT_PORT && in_data_i.src_port == '0
      |=> stg_q_ff == $past(port_level_i[1:0]))
      else $error("port level not applied");
   a_cos_map: assert property (@(posedge clock_i)
      disable iff (srst_i)
      accept && ptype_i == PT_COS_ONLY && in_data_i.cos_vld
      |=> stg_q_ff == $past(cos_tab_ff[in_data_i.cos]))
      else $error("cos mapping not applied");
   a_dscp_write: assert property (@(posedge clock_i)
      disable iff (srst_i)
      dscp_wr_i.we |=> dscp_tab_ff[$past(dscp_wr_i.addr)]
      == $past(dscp_wr_i.level))
      else $error("dscp table write lost");
   a_dscp_reset: assert property (@(posedge clock_i)
      $fell(srst_i) |-> dscp_tab_ff == {DSCP_N{Q_LOWEST}})
      else $error("dscp table not lowest after reset");
   a_dscp_map: assert property (@(posedge clock_i)
      disable iff (srst_i)
      accept && ptype_i == PT_TOS_ONLY && in_data_i.ip_vld
      |=> stg_q_ff == $past(dscp_tab_ff[in_data_i.dscp]))
      else $error("dscp mapping not applied");
   a_tos_fallback: assert property (@(posedge clock_i)
      disable iff (srst_i)
      accept && ptype_i == PT_TOS_FIRST && !in_data_i.ip_vld
      && in_data_i.cos_vld
      |=> stg_q_ff == $past(cos_tab_ff[in_data_i.cos]))
      else $error("tos-first fallback to cos missing");
endmodule

// File: hdl/qcs_fifo.sv
// descriptor fifo with valid/ready on both sides
// assumes synchronous active-high reset on the same clock
`timescale 1ns/1ps
module qcs_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input logic clock_i,
   input logic srst_i,
   input logic in_valid_i,
   output logic in_ready_o,
   input logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two");
   end
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic push, pop;
   // ****************************************
   // pointers and count
   // ****************************************
   assign in_ready_o = (cnt_ff != FULL);
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o = mem[rd_ff];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   always_comb begin
      nxt_wr = wr_ff + AW'(push);
      nxt_rd = rd_ff + AW'(pop);
      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wr_ff] <= in_data_i;
      end
   end
endmodule

// File: inc/qcs_pkg.sv
// qos classifier/scheduler constants, types and descriptor layout
// assumes one switch clock; configuration comes from same-clock logic
package qcs_pkg;
   // ****************************************
   // queues and weights
   // ****************************************
   localparam int NQ = 4;
   localparam logic [1:0] Q_HIGH = 2'h0;
   localparam logic [1:0] Q_MIDDLE = 2'h1;
   localparam logic [1:0] Q_LOW = 2'h2;
   localparam logic [1:0] Q_LOWEST = 2'h3;
   localparam int CRED_W = 4;
   localparam logic [NQ-1:0][CRED_W-1:0] WEIGHTS =
      {4'h1, 4'h2, 4'h4, 4'h8};
   // ****************************************
   // tables and reset values
   // ****************************************
   localparam int COS_N = 8;
   localparam int DSCP_N = 64;
   localparam logic [1:0] COS_RST = Q_LOWEST;
   localparam logic [1:0] DSCP_RST = Q_LOWEST;
   // ****************************************
   // descriptor fields
   // ****************************************
   localparam int HANDLE_W = 16;
   localparam int PORT_W = 4;
   localparam int MAX_PORTS = 16;
   typedef enum logic {POL_WEIGHTED, POL_STRICT} qcs_policy_e;
   typedef enum logic [2:0] {
      PT_DISABLE, PT_PORT, PT_TOS_ONLY, PT_COS_ONLY,
      PT_TOS_FIRST, PT_COS_FIRST
   } qcs_ptype_e;
   typedef struct packed {
      logic [HANDLE_W-1:0] handle;
      logic [PORT_W-1:0] src_port;
      logic cos_vld;
      logic [2:0] cos;
      logic ip_vld;
      logic [5:0] dscp;
   } qcs_desc_s;
   typedef struct packed {
      qcs_desc_s desc;
      logic [1:0] queue;
   } qcs_out_s;
   typedef struct packed {
      logic we;
      logic [5:0] addr;
      logic [1:0] level;
   } qcs_tab_wr_s;
endpackage

// File: tb/qcs_classifier_scheduler_test.sv
// self-checking bench for the classifier and scheduler
// assumes the egress model on the output side
`timescale 1ns/1ps
module qcs_classifier_scheduler_test;
   import qcs_pkg::*;
   logic clock_i = 0;
   logic srst_i = 1;
   logic stall = 0;
   logic slow = 0;
   logic in_valid = 0;
   logic in_ready;
   logic out_valid;
   logic out_ready;
   qcs_policy_e policy = POL_STRICT;
   qcs_ptype_e ptype = PT_DISABLE;
   logic [7:0] plev = 8'h1b;
   qcs_tab_wr_s cwr = '0;
   qcs_tab_wr_s dwr = '0;
   qcs_desc_s din = '0;
   qcs_out_s dout;
   logic [1:0] got[$];
   logic [1:0] ex[$];
   qcs_desc_s gd[$];
   qcs_desc_s exd[$];
   int error_cnt = 0;
   int checks = 0;
   always #4 clock_i = ~clock_i;
   qcs_classifier_scheduler #(.NPORT(4), .QDEPTH(8)) DUT (
      .clock_i(clock_i), .srst_i(srst_i), .policy_i(policy),
      .ptype_i(ptype), .port_level_i(plev), .cos_wr_i(cwr),
      .dscp_wr_i(dwr), .in_valid_i(in_valid), .in_ready_o(in_ready),
      .in_data_i(din), .out_valid_o(out_valid),
      .out_ready_i(out_ready), .out_data_o(dout));
   qcs_egress_model EGR (.clock_i(clock_i), .srst_i(srst_i),
      .stall_i(stall), .slow_i(slow), .out_ready_o(out_ready));
   always @(posedge clock_i) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         got.push_back(dout.queue);
         gd.push_back(dout.desc);
      end
   end
   task automatic test_done();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmp(string nm, logic [1:0] e, logic [1:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cmp_desc(string nm, qcs_desc_s e, qcs_desc_s g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s descriptor exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(bit d, int a, logic [1:0] l);
      @(negedge clock_i);
      if (d)
         dwr = '{1'b1, 6'(a), l};
      else
         cwr = '{1'b1, 6'(a), l};
      @(negedge clock_i);
      dwr.we = 1'b0;
      cwr.we = 1'b0;
   endtask
   task automatic send(qcs_ptype_e t, logic [3:0] p, logic cv,
         logic [2:0] c, logic iv, logic [5:0] ds, logic [1:0] e);
      int n;
      n = 0;
      @(negedge clock_i);
      ptype = t;
      din = '{16'(checks), p, cv, c, iv, ds};
      in_valid = 1'b1;
      ex.push_back(e);
      exd.push_back(din);
      while (in_ready !== 1'b1 && n++ < 100) @(negedge clock_i);
      @(negedge clock_i);
      in_valid = 1'b0;
   endtask
   task automatic burst(int p, int n);
      repeat (n) send(PT_PORT, 4'(p), 0, 0, 0, 0, 2'(3 - p));
   endtask
   task automatic expect_seq(string nm);
      int n;
      n = 0;
      repeat (3) @(negedge clock_i);
      stall = 1'b0;
      while (got.size() < ex.size() && n++ < 500) @(negedge clock_i);
      foreach (ex[i]) cmp(nm, ex[i], got[i]);
      foreach (exd[i]) cmp_desc(nm, exd[i], gd[i]);
      got.delete();
      ex.delete();
      gd.delete();
      exd.delete();
      $display("test %s done", nm);
   endtask
   task automatic t_tables();
      send(PT_TOS_ONLY, 0, 1, 1, 1, 25, Q_LOWEST);
      send(PT_TOS_ONLY, 0, 0, 0, 1, 63, Q_LOWEST);
      wr(1, 25, Q_HIGH);
      wr(1, 63, Q_LOW);
      send(PT_TOS_ONLY, 0, 0, 0, 1, 25, Q_HIGH);
      send(PT_TOS_ONLY, 0, 0, 0, 1, 63, Q_LOW);
      send(PT_TOS_ONLY, 0, 1, 0, 0, 25, Q_LOWEST);
      expect_seq("dscp");
   endtask
   task automatic t_cos();
      for (int i = 0; i < 8; i++)
         wr(0, i, 2'(~i));
      for (int i = 0; i < 8; i++)
         send(PT_COS_ONLY, 0, 1, 3'(i), 0, 0, 2'(~i));
      expect_seq("cos");
   endtask
   task automatic t_modes();
      send(PT_TOS_FIRST, 0, 1, 1, 1, 25, Q_HIGH);
      send(PT_TOS_FIRST, 0, 1, 1, 0, 25, Q_LOW);
      send(PT_COS_FIRST, 0, 1, 1, 1, 25, Q_LOW);
      send(PT_COS_FIRST, 0, 0, 1, 1, 25, Q_HIGH);
      send(PT_DISABLE, 0, 1, 1, 1, 25, Q_LOWEST);
      send(PT_COS_ONLY, 0, 0, 1, 1, 25, Q_LOWEST);
      for (int p = 0; p < 4; p++)
         burst(p, 1);
      send(PT_PORT, 4'h5, 1, 0, 1, 25, Q_LOWEST);
      expect_seq("modes");
   endtask
   task automatic t_strict();
      stall = 1'b1;
      burst(0, 2);
      burst(2, 1);
      burst(3, 2);
      ex = '{Q_LOWEST, Q_HIGH, Q_HIGH, Q_MIDDLE, Q_LOWEST};
      exd.delete();
      slow = 1'b1;
      expect_seq("strict");
      slow = 1'b0;
   endtask
   task automatic t_weight();
      policy = POL_WEIGHTED;
      stall = 1'b1;
      burst(0, 1);
      burst(3, 8);
      burst(2, 4);
      burst(1, 2);
      burst(0, 2);
      expect_seq("weighted");
   endtask
   task automatic t_wrr_share();
      stall = 1'b1;
      burst(3, 1);
      burst(2, 1);
      burst(3, 9);
      ex.delete();
      exd.delete();
      repeat (9) ex.push_back(Q_HIGH);
      ex.push_back(Q_MIDDLE);
      ex.push_back(Q_HIGH);
      expect_seq("share");
   endtask
   task automatic t_reset();
      stall = 1'b1;
      wr(0, 1, Q_HIGH);
      burst(3, 1);
      @(negedge clock_i);
      srst_i = 1'b1;
      stall = 1'b0;
      repeat (2) @(negedge clock_i);
      srst_i = 1'b0;
      ex.delete();
      exd.delete();
      @(negedge clock_i);
      cmp("rst_ready", 2'h1, {1'b0, in_ready});
      cmp("rst_valid", 2'h0, {1'b0, out_valid});
      send(PT_TOS_ONLY, 0, 1, 1, 1, 25, Q_LOWEST);
      send(PT_COS_ONLY, 0, 1, 1, 0, 0, Q_LOWEST);
      expect_seq("reset");
   endtask
   initial begin
      repeat (3000) @(posedge clock_i);
      error_cnt++;
      test_done();
   end
   initial begin
      repeat (10) @(negedge clock_i);
      srst_i = 1'b0;
      repeat (2) @(negedge clock_i);
      t_tables();
      t_cos();
      t_modes();
      t_strict();
      t_weight();
      t_wrr_share();
      t_reset();
      test_done();
   end
endmodule

// File: tb/qcs_egress_model.sv
// egress transmitter model: takes frames promptly, every other cycle, or none while stalled
// assumes the scheduler's clock and reset
`timescale 1ns/1ps
module qcs_egress_model (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic stall_i,
   input wire logic slow_i,
   output logic out_ready_o
);
   logic ph_ff;
   always_ff @(posedge clock_i) begin
      ph_ff <= srst_i ? 1'b0 : ~ph_ff;
      out_ready_o <= ~srst_i & ~stall_i & (~slow_i | ph_ff);
   end
endmodule
